// ---- hw/pfb_bus_if.sv ----
// Interface carrying the pin-pair drive data from the register file to the output mux.
// Assumes both ends share core_clk.
`timescale 1ns/1ps
`default_nettype none
interface pfb_bus_if;
    logic [7:0] pwm_gen;
    logic [7:0] ovd_sel;
    logic [7:0] ovd_out;
    logic [7:0] fault_force;
    logic [7:0] fault_level;
    logic [7:0] pin_out;
    modport ctrl (output pwm_gen, output ovd_sel, output ovd_out, output fault_force,
                  output fault_level, input pin_out);
    modport mux (input pwm_gen, input ovd_sel, input ovd_out, input fault_force,
                 input fault_level, output pin_out);
endinterface
`default_nettype wire

// ---- hw/pfb_ctrl.sv ----
// Fault B / fault A arbitration, override register and write lock for one PWM unit.
// Assumes fault inputs already synchronous and active high; pins active high.
`timescale 1ns/1ps
`default_nettype none
module pfb_ctrl
    import pfb_pkg::*;
#(
    parameter bit LOCK_OPTION_PRESENT = 1'b1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Configuration
    input wire logic write_lock_option,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    // Fault inputs and generator outputs
    input wire logic fault_a_in,
    input wire logic fault_b_in,
    input wire logic [7:0] pwm_gen,
    // Pins, bit 2k is pair k+1 low, bit 2k+1 pair k+1 high
    output logic [7:0] pwm_pin
);
    //////////////////////////////////////////////////////////////////////
    logic [15:0] fltb_q;
    logic [15:0] flta_q;
    logic [15:0] ovd_q;
    logic [15:0] rdata_q;
    logic lock_q;
    pfb_key_type key_q;
    logic open_w;
    logic fa_lat_q;
    logic fb_lat_q;
    logic [7:0] force_d;
    logic [7:0] force_q;
    logic [7:0] level_d;
    logic [7:0] level_q;
    pfb_bus_if bus ();

    // Strap is sampled by a clocked process so reset only loads constants
    always_ff @(posedge core_clk) begin
        lock_q <= write_lock_option;
    end

    //////////////////////////////////////////////////////////////////////
    // Unlock key: a fault register write is accepted right after the pair
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            key_q <= PFB_KEY_IDLE;
        end else if (wr) begin
            if (addr == PFB_ADDR_KEY && wdata == PFB_KEY_FIRST) begin
                key_q <= PFB_KEY_HALF;
            end else if (addr == PFB_ADDR_KEY && wdata == PFB_KEY_SECOND
                         && key_q == PFB_KEY_HALF) begin
                key_q <= PFB_KEY_OPEN;
            end else begin
                key_q <= PFB_KEY_IDLE;
            end
        end
    end
    assign open_w = !lock_q || (key_q == PFB_KEY_OPEN);

    //////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            fltb_q <= LOCK_OPTION_PRESENT ? 16'h000F : 16'h0000;
        end else if (wr && addr == PFB_ADDR_FLTB && open_w) begin
            fltb_q <= wdata & PFB_FLTB_WMASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            flta_q <= PFB_FLTA_RST;
        end else if (wr && addr == PFB_ADDR_FLTA && open_w) begin
            flta_q <= wdata & PFB_FLTB_WMASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ovd_q <= PFB_OVD_RST;
        end else if (wr && addr == PFB_ADDR_OVD) begin
            ovd_q <= wdata;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Latched mode holds the fault until software rewrites the register
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            fa_lat_q <= 1'b0;
        end else if (fault_a_in) begin
            fa_lat_q <= 1'b1;
        end else if (wr && addr == PFB_ADDR_FLTA && open_w) begin
            fa_lat_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            fb_lat_q <= 1'b0;
        end else if (fault_b_in) begin
            fb_lat_q <= 1'b1;
        end else if (wr && addr == PFB_ADDR_FLTB && open_w) begin
            fb_lat_q <= 1'b0;
        end
    end

    function automatic logic fault_act(input logic [15:0] c, input logic pin_lvl,
                                       input logic lat);
        fault_act = pin_lvl || (c[PFB_FLTB_MODE_BIT] == 1'b0 && lat);
    endfunction

    always_comb begin
        force_d = 8'h00;
        level_d = 8'h00;
        for (int p = 0; p < PFB_PAIRS; p++) begin
            if (flta_q[PFB_FLTB_EN_LSB + p] && fault_act(flta_q, fault_a_in, fa_lat_q)) begin
                force_d[2*p +: 2] = 2'b11;
                level_d[2*p +: 2] = flta_q[PFB_FLTB_OV_LSB + 2*p +: 2];
            end else if (fltb_q[PFB_FLTB_EN_LSB + p]
                         && fault_act(fltb_q, fault_b_in, fb_lat_q)) begin
                force_d[2*p +: 2] = 2'b11;
                level_d[2*p +: 2] = fltb_q[PFB_FLTB_OV_LSB + 2*p +: 2];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            force_q <= 8'h00;
            level_q <= 8'h00;
        end else begin
            force_q <= force_d;
            level_q <= level_d;
        end
    end

    assign bus.pwm_gen = pwm_gen;
    assign bus.ovd_sel = ovd_q[15:8];
    assign bus.ovd_out = ovd_q[7:0];
    assign bus.fault_force = force_q;
    assign bus.fault_level = level_q;

    pfb_out_mux u_mux (
        .core_clk(core_clk),
        .nrst(nrst),
        .bus(bus)
    );
    assign pwm_pin = bus.pin_out;

    //////////////////////////////////////////////////////////////////////
    // Read port; unmapped addresses read zero
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            rdata_q <= 16'h0000;
        end else if (rd) begin
            if (addr == PFB_ADDR_FLTB) begin
                rdata_q <= fltb_q;
            end else if (addr == PFB_ADDR_FLTA) begin
                rdata_q <= flta_q;
            end else if (addr == PFB_ADDR_OVD) begin
                rdata_q <= ovd_q;
            end else if (addr == PFB_ADDR_STAT) begin
                rdata_q <= {8'h00, force_q};
            end else begin
                rdata_q <= 16'h0000;
            end
        end else begin
            rdata_q <= 16'h0000;
        end
    end
    assign rdata = rdata_q;

    //////////////////////////////////////////////////////////////////////
    a_unimpl_zero: assert property (@(posedge core_clk) disable iff (!nrst)
        fltb_q[6:4] == 3'b000)
        else $error("unimplemented bits set");
    a_fltb_gate: assert property (@(posedge core_clk) disable iff (!nrst)
        (!fltb_q[0] && !flta_q[0]) |=> (force_q[1:0] == 2'b00))
        else $error("disabled pair forced");
    a_fltb_force: assert property (@(posedge core_clk) disable iff (!nrst)
        (fltb_q[3] && fault_b_in && !flta_q[3]) |=> (force_q[7:6] == 2'b11
        && level_q[7:6] == $past(fltb_q[15:14])))
        else $error("fault B not applied");
    a_fa_priority: assert property (@(posedge core_clk) disable iff (!nrst)
        (flta_q[1] && fault_a_in && fltb_q[1] && fault_b_in)
        |=> (level_q[3:2] == $past(flta_q[11:10])))
        else $error("fault A lost priority");
    a_lock_write: assert property (@(posedge core_clk) disable iff (!nrst)
        (wr && addr == PFB_ADDR_FLTB && lock_q && key_q != PFB_KEY_OPEN)
        |=> $stable(fltb_q))
        else $error("locked write took effect");
    a_ovd_write: assert property (@(posedge core_clk) disable iff (!nrst)
        (wr && addr == PFB_ADDR_OVD) |=> (ovd_q == $past(wdata)))
        else $error("override write lost");
endmodule
`default_nettype wire

// ---- hw/pfb_out_mux.sv ----
// Output selection per pin: fault, then generator where the select bit is set, else manual level.
// Assumes registered inputs; the pins are registered here.
`timescale 1ns/1ps
`default_nettype none
module pfb_out_mux
    import pfb_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Pin data
    pfb_bus_if.mux bus
);
    logic [7:0] pin_d;
    logic [7:0] pin_q;
    genvar i;
    generate
        for (i = 0; i < PFB_PINS; i++) begin : g_pin
            always_comb begin
                if (bus.fault_force[i]) begin
                    pin_d[i] = bus.fault_level[i];
                end else if (bus.ovd_sel[i]) begin
                    pin_d[i] = bus.pwm_gen[i];
                end else begin
                    pin_d[i] = bus.ovd_out[i];
                end
            end
        end
    endgenerate
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            pin_q <= 8'h00;
        end else begin
            pin_q <= pin_d;
        end
    end
    assign bus.pin_out = pin_q;

    a_override_pass: assert property (@(posedge core_clk) disable iff (!nrst)
        (!bus.fault_force[0] && !bus.ovd_sel[0]) |=> (pin_q[0] == $past(bus.ovd_out[0])))
        else $error("manual level not passed");
    a_gen_pass: assert property (@(posedge core_clk) disable iff (!nrst)
        (!bus.fault_force[1] && bus.ovd_sel[1]) |=> (pin_q[1] == $past(bus.pwm_gen[1])))
        else $error("generator not passed");
    a_fault_level: assert property (@(posedge core_clk) disable iff (!nrst)
        bus.fault_force[2] |=> (pin_q[2] == $past(bus.fault_level[2])))
        else $error("fault level not forced");
endmodule
`default_nettype wire

// ---- hw/pfb_pkg.sv ----
// Package for the fault B / override control block of the PWM unit.
// Assumes a 16-bit register port with one-cycle read latency.
package pfb_pkg;
    localparam int PFB_PAIRS = 4;
    localparam int PFB_PINS = 8;
    // Register addresses (word index on the local port)
    localparam logic [3:0] PFB_ADDR_FLTB = 4'h0;
    localparam logic [3:0] PFB_ADDR_OVD = 4'h1;
    localparam logic [3:0] PFB_ADDR_FLTA = 4'h2;
    localparam logic [3:0] PFB_ADDR_KEY = 4'h3;
    localparam logic [3:0] PFB_ADDR_STAT = 4'h4;
    // Fault B control field positions
    localparam int PFB_FLTB_EN_LSB = 0;
    localparam int PFB_FLTB_MODE_BIT = 7;
    localparam int PFB_FLTB_OV_LSB = 8;
    // Fault A control uses the same layout
    localparam logic [15:0] PFB_FLTB_WMASK = 16'hFF8F;
    // Override control reset value: all select bits set, manual bits clear
    localparam logic [15:0] PFB_OVD_RST = 16'hFF00;
    localparam logic [15:0] PFB_FLTA_RST = 16'h0000;
    // Unlock key sequence, two consecutive writes to the key register
    localparam logic [15:0] PFB_KEY_FIRST = 16'hABCD;
    localparam logic [15:0] PFB_KEY_SECOND = 16'h4321;
    typedef enum logic [1:0] {PFB_KEY_IDLE, PFB_KEY_HALF, PFB_KEY_OPEN} pfb_key_type;
endpackage

// ---- test/pfb_stage_model.sv ----
// Far-side model: the fault sensors of the power stage.
// Assumes trip commands from the bench, sampled on core_clk.
`timescale 1ns/1ps
`default_nettype none
module pfb_stage_model (
    // Clock
    input wire logic core_clk,
    // Trip commands, bit 0 fault A, bit 1 fault B
    input wire logic [1:0] trip_cmd,
    // Fault lines toward the block
    output logic fault_a_out = 1'b0,
    output logic fault_b_out = 1'b0
);
    // A comparator stage reports a trip one clock late, never at once
    always_ff @(posedge core_clk) begin
        fault_a_out <= trip_cmd[0];
        fault_b_out <= trip_cmd[1];
    end
endmodule
`default_nettype wire

// ---- test/tb_pfb_ctrl.sv ----
// Testbench for the fault B / override control block.
// Assumes the sensor model and a 16-bit register port, read data one cycle late.
`timescale 1ns/1ps
`default_nettype none
module tb_pfb_ctrl;
    import pfb_pkg::*;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic write_lock_option = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic [1:0] trip_cmd = 2'b00;
    logic fault_a_in;
    logic fault_b_in;
    logic [7:0] pwm_gen = 8'h00;
    logic [7:0] pwm_pin;
    logic [15:0] fa_q;
    logic [15:0] fb_q;
    logic [15:0] ov_q;
    int n_errors = 0;
    int samples_checked = 0;
    int seed = 51303;
    int cycles = 0;

    pfb_ctrl #(.LOCK_OPTION_PRESENT(1'b1)) i_pfb_ctrl (.core_clk(core_clk), .nrst(nrst),
        .write_lock_option(write_lock_option), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .fault_a_in(fault_a_in), .fault_b_in(fault_b_in),
        .pwm_gen(pwm_gen), .pwm_pin(pwm_pin));
    pfb_stage_model i_pfb_stage_model (.core_clk(core_clk), .trip_cmd(trip_cmd),
        .fault_a_out(fault_a_in), .fault_b_out(fault_b_in));

    initial begin
        forever #10 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp);
    endtask

    // Per pin: fault A, then fault B, then select bit, then manual bit
    function automatic logic [7:0] exp_pins(input logic fa, input logic fb);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) begin
            if (fa && fa_q[i/2]) r[i] = fa_q[8+i];
            else if (fb && fb_q[i/2]) r[i] = fb_q[8+i];
            else if (ov_q[8+i]) r[i] = pwm_gen[i];
            else r[i] = ov_q[i];
        end
        return r;
    endfunction

    // Sensor delay, force register and pin register all lie in the path
    task automatic pins(input logic [1:0] t);
        @(posedge core_clk);
        trip_cmd <= t;
        repeat (4) @(posedge core_clk);
        #1;
        check({8'h00, pwm_pin}, {8'h00, exp_pins(t[0], t[1])});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge core_clk);
        nrst <= 1'b1;
        rd_chk(PFB_ADDR_FLTB, 16'h000F);
        rd_chk(PFB_ADDR_OVD, 16'hFF00);
        $display("test reset_values done");
        @(posedge core_clk);
        write_lock_option <= 1'b1;
        wr_reg(PFB_ADDR_FLTB, 16'h0080);
        rd_chk(PFB_ADDR_FLTB, 16'h000F);
        wr_reg(PFB_ADDR_FLTA, 16'hFFFF);
        rd_chk(PFB_ADDR_FLTA, 16'h0000);
        wr_reg(PFB_ADDR_KEY, PFB_KEY_FIRST);
        wr_reg(PFB_ADDR_KEY, PFB_KEY_SECOND);
        wr_reg(PFB_ADDR_FLTB, 16'hFFFF);
        rd_chk(PFB_ADDR_FLTB, 16'hFF8F);
        rd_chk(4'hF, 16'h0000);
        $display("test lock_and_unused done");
        @(posedge core_clk);
        write_lock_option <= 1'b0;
        for (int k = 0; k < 60; k++) begin
            fa_q = (16'($random(seed)) & 16'hFF8F) | 16'h0080;
            fb_q = (16'($random(seed)) & 16'hFF8F) | 16'h0080;
            ov_q = 16'($random(seed));
            if (k == 3) begin
                fa_q[3:0] = 4'hF;
                fb_q[3:0] = 4'hF;
            end
            wr_reg(PFB_ADDR_FLTA, fa_q);
            wr_reg(PFB_ADDR_FLTB, fb_q);
            wr_reg(PFB_ADDR_OVD, ov_q);
            pwm_gen <= 8'($random(seed));
            pins(k[1:0]);
        end
        $display("test pin_priority done");
        pins(2'b00);
        fa_q = 16'h0080;
        fb_q = 16'h0201;
        ov_q = 16'h0000;
        wr_reg(PFB_ADDR_FLTA, fa_q);
        wr_reg(PFB_ADDR_FLTB, fb_q);
        wr_reg(PFB_ADDR_OVD, ov_q);
        pins(2'b00);
        pins(2'b10);
        // Latched mode: the trip has gone but pair 1 must stay forced
        @(posedge core_clk);
        trip_cmd <= 2'b00;
        repeat (4) @(posedge core_clk);
        #1;
        check({8'h00, pwm_pin}, 16'h0002);
        rd_chk(PFB_ADDR_STAT, 16'h0003);
        wr_reg(PFB_ADDR_FLTB, fb_q);
        pins(2'b00);
        $display("test latched_fault done");
        test_done();
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            test_done();
        end
    end
endmodule
`default_nettype wire
